// ==== hdl/pie_map_pkg.sv ====
`default_nettype none

package pie_map_pkg;

  // ********************************************************************
  // Sizes
  // ********************************************************************
  localparam int NUM_SOURCES = 19;
  localparam int NUM_LINES = 3;
  localparam int REG_WIDTH = 16;
  localparam int REG_COUNT = 3;
  localparam int REQ_BITS = REG_COUNT * REG_WIDTH;

  typedef logic [15:0] vector_t;
  typedef logic [5:0] prio_t;
  typedef logic [1:0] line_t;
  typedef logic [1:0] reg_idx_t;
  typedef logic [3:0] bit_pos_t;
  typedef logic [4:0] src_idx_t;
  typedef logic [5:0] flat_pos_t;
  typedef logic [NUM_SOURCES-1:0] src_mask_t;
  typedef logic [REQ_BITS-1:0] req_regs_t;

  typedef enum logic [1:0] {
    GROUP_SERIAL = 2'b00,
    GROUP_CAN = 2'b01,
    GROUP_FIRST_EM = 2'b10,
    GROUP_SECOND_EM = 2'b11
  } group_e;

  // ********************************************************************
  // Core lines
  // ********************************************************************
  localparam line_t LINE_ONE = 2'h0;
  localparam line_t LINE_TWO = 2'h1;
  localparam line_t LINE_THREE = 2'h2;
  localparam line_t LINE_INVALID = 2'h3;
  localparam vector_t LINE_CORE_ADDRESS [0:NUM_LINES-1] = '{16'h0002, 16'h0004, 16'h0006};
  // Answered when the core acknowledges a line with nothing pending
  localparam vector_t PHANTOM_VECTOR = 16'h0000;

  // ********************************************************************
  // Source table, listed in ascending overall priority number
  // ********************************************************************
  typedef struct packed {
    vector_t vector;
    reg_idx_t reg_idx;
    bit_pos_t bit_pos;
    prio_t prio;
    line_t line;
    group_e group;
  } source_entry_s;

  localparam src_idx_t SRC_SERIAL_TRANSMIT = 5'h00;
  localparam src_idx_t SRC_CAN_MAILBOX = 5'h01;
  localparam src_idx_t SRC_CAN_ERROR = 5'h02;
  localparam src_idx_t SRC_TIMER_ONE_PERIOD = 5'h03;
  localparam src_idx_t SRC_TIMER_THREE_OVERFLOW = 5'h0A;
  localparam src_idx_t SRC_TIMER_TWO_PERIOD = 5'h0B;

  localparam source_entry_s SOURCE_TABLE [0:NUM_SOURCES-1] = '{
    '{16'h0007, 2'h0, 4'h6, 6'h0B, LINE_ONE, GROUP_SERIAL},
    '{16'h0040, 2'h0, 4'h7, 6'h0C, LINE_ONE, GROUP_CAN},
    '{16'h0041, 2'h0, 4'h8, 6'h0D, LINE_ONE, GROUP_CAN},
    '{16'h0027, 2'h0, 4'hC, 6'h11, LINE_TWO, GROUP_FIRST_EM},
    '{16'h0028, 2'h0, 4'hD, 6'h12, LINE_TWO, GROUP_FIRST_EM},
    '{16'h0029, 2'h0, 4'hE, 6'h13, LINE_TWO, GROUP_FIRST_EM},
    '{16'h002A, 2'h0, 4'hF, 6'h14, LINE_TWO, GROUP_FIRST_EM},
    '{16'h002F, 2'h2, 4'h4, 6'h18, LINE_TWO, GROUP_SECOND_EM},
    '{16'h0030, 2'h2, 4'h5, 6'h19, LINE_TWO, GROUP_SECOND_EM},
    '{16'h0031, 2'h2, 4'h6, 6'h1A, LINE_TWO, GROUP_SECOND_EM},
    '{16'h0032, 2'h2, 4'h7, 6'h1B, LINE_TWO, GROUP_SECOND_EM},
    '{16'h002B, 2'h1, 4'h0, 6'h1C, LINE_THREE, GROUP_FIRST_EM},
    '{16'h002C, 2'h1, 4'h1, 6'h1D, LINE_THREE, GROUP_FIRST_EM},
    '{16'h002D, 2'h1, 4'h2, 6'h1E, LINE_THREE, GROUP_FIRST_EM},
    '{16'h002E, 2'h1, 4'h3, 6'h1F, LINE_THREE, GROUP_FIRST_EM},
    '{16'h0039, 2'h2, 4'h8, 6'h20, LINE_THREE, GROUP_SECOND_EM},
    '{16'h003A, 2'h2, 4'h9, 6'h21, LINE_THREE, GROUP_SECOND_EM},
    '{16'h003B, 2'h2, 4'hA, 6'h22, LINE_THREE, GROUP_SECOND_EM},
    '{16'h003C, 2'h2, 4'hB, 6'h23, LINE_THREE, GROUP_SECOND_EM}
  };

  // Word index and bit joined: word * 16 + bit
  function automatic flat_pos_t flat_pos(input int s);
    return {SOURCE_TABLE[s].reg_idx, SOURCE_TABLE[s].bit_pos};
  endfunction : flat_pos

  function automatic src_mask_t line_mask(input line_t ln);
    src_mask_t m;
    m = '0;
    for (int s = 0; s < NUM_SOURCES; s++) begin
      m[s] = (SOURCE_TABLE[s].line == ln);
    end
    return m;
  endfunction : line_mask

  typedef struct packed {
    logic [NUM_LINES-1:0] lines;
    vector_t vector;
    vector_t core_address;
    req_regs_t ack_regs;
  } map_state_s;

endpackage : pie_map_pkg

`default_nettype wire

// ==== hdl/line_arb_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface line_arb_if;
  import pie_map_pkg::*;
  src_mask_t pending;
  logic hit;
  src_idx_t winner;
  vector_t vector;
  modport host (output pending, input hit, input winner, input vector);
  modport arb (input pending, output hit, output winner, output vector);
endinterface : line_arb_if

`default_nettype wire

// ==== hdl/request_slot.sv ====
`timescale 1ns/1ps
`default_nettype none

module request_slot import pie_map_pkg::*; #(
  parameter bit PRESENT = 1'b1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic request_i,
  input wire logic enable_i,
  input wire logic clear_i,
  output logic pending_o
);

  typedef struct packed {
    logic pending;
  } slot_state_s;

  slot_state_s state;
  slot_state_s next_state;
  logic set;

  // An absent peripheral can never raise its bit
  assign set = PRESENT && request_i && enable_i;

  always_comb begin
    next_state = state;
    if (clear_i) begin
      next_state.pending = 1'b0;
    end
    // Set after clear so a same-cycle event survives the acknowledge
    if (set) begin
      next_state.pending = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pending_o = state.pending;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_set_beats_clear: assert property (set |=> pending_o)
    else $error("request lost");
  a_holds_till_ack: assert property (pending_o && !clear_i |=> pending_o)
    else $error("pending dropped without acknowledge");
  a_clear_drops: assert property (clear_i && !set |=> !pending_o)
    else $error("acknowledge did not clear");
  a_enable_gates: assert property (!pending_o && !enable_i |=> !pending_o)
    else $error("disabled event became pending");
  a_absent_quiet: assert property (!PRESENT |-> !pending_o)
    else $error("absent source pending");

endmodule : request_slot

`default_nettype wire

// ==== hdl/line_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none

module line_arbiter import pie_map_pkg::*; #(
  parameter line_t LINE = LINE_ONE
) (
  line_arb_if.arb bus
);

  logic found;
  src_idx_t best;
  prio_t best_prio;

  // Linear scan; nineteen sources keep the compare chain short
  always_comb begin
    found = 1'b0;
    best = '0;
    best_prio = '1;
    for (int s = 0; s < NUM_SOURCES; s++) begin
      if (bus.pending[s] && SOURCE_TABLE[s].line == LINE
          && (!found || SOURCE_TABLE[s].prio < best_prio)) begin
        found = 1'b1;
        best = src_idx_t'(s);
        best_prio = SOURCE_TABLE[s].prio;
      end
    end
  end

  assign bus.hit = found;
  assign bus.winner = best;
  assign bus.vector = found ? SOURCE_TABLE[best].vector : PHANTOM_VECTOR;

endmodule : line_arbiter

`default_nettype wire

// ==== hdl/peripheral_interrupt_expansion_map.sv ====
`timescale 1ns/1ps
`default_nettype none

module peripheral_interrupt_expansion_map import pie_map_pkg::*; #(
  parameter bit HAS_SERIAL = 1'b1,
  parameter bit HAS_CAN = 1'b1,
  parameter bit HAS_FIRST_EM = 1'b1,
  parameter bit HAS_SECOND_EM = 1'b1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [NUM_SOURCES-1:0] source_request_i,
  input wire logic [NUM_SOURCES-1:0] source_enable_i,
  input wire logic ack_i,
  input wire logic [1:0] ack_line_i,
  output logic [REQ_BITS-1:0] peripheral_request_regs_o,
  output logic [REQ_BITS-1:0] peripheral_acknowledge_regs_o,
  output logic core_line_one_o,
  output logic core_line_two_o,
  output logic core_line_three_o,
  output logic [15:0] peripheral_vector_code_o,
  output logic [15:0] core_vector_address_o
);

  // ********************************************************************
  // Pending bits
  // ********************************************************************
  src_mask_t pending;
  src_mask_t clear;
  logic line_hit [0:NUM_LINES-1];
  src_idx_t line_winner [0:NUM_LINES-1];
  vector_t line_vector [0:NUM_LINES-1];

  for (genvar s = 0; s < NUM_SOURCES; s++) begin : g_slot
    localparam group_e GRP = SOURCE_TABLE[s].group;
    localparam bit PRESENT = (GRP == GROUP_SERIAL) ? HAS_SERIAL :
                             (GRP == GROUP_CAN) ? HAS_CAN :
                             (GRP == GROUP_FIRST_EM) ? HAS_FIRST_EM : HAS_SECOND_EM;
    request_slot #(
      .PRESENT(PRESENT)
    ) u_slot (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .request_i(source_request_i[s]),
      .enable_i(source_enable_i[s]),
      .clear_i(clear[s]),
      .pending_o(pending[s])
    );
  end

  // ********************************************************************
  // Per-line arbitration
  // ********************************************************************
  line_arb_if arb_bus [NUM_LINES] ();

  for (genvar l = 0; l < NUM_LINES; l++) begin : g_line
    assign arb_bus[l].pending = pending;
    assign line_hit[l] = arb_bus[l].hit;
    assign line_winner[l] = arb_bus[l].winner;
    assign line_vector[l] = arb_bus[l].vector;
    line_arbiter #(
      .LINE(line_t'(l))
    ) u_arb (
      .bus(arb_bus[l])
    );
  end

  // ********************************************************************
  // Request register view
  // ********************************************************************
  req_regs_t request_regs;

  always_comb begin
    request_regs = '0;
    for (int s = 0; s < NUM_SOURCES; s++) begin
      request_regs[flat_pos(s)] = pending[s];
    end
  end

  assign peripheral_request_regs_o = request_regs;

  // ********************************************************************
  // Acknowledge handling and core lines
  // ********************************************************************
  map_state_s state;
  map_state_s next_state;
  logic ack_legal;
  src_mask_t still_pending;

  assign ack_legal = ack_i && (ack_line_i != LINE_INVALID);

  always_comb begin
    next_state = state;
    next_state.ack_regs = '0;
    clear = '0;
    if (ack_legal) begin
      // Vector is latched at the acknowledge so it cannot shift under the core
      next_state.core_address = LINE_CORE_ADDRESS[ack_line_i];
      next_state.vector = line_vector[ack_line_i];
      if (line_hit[ack_line_i]) begin
        clear[line_winner[ack_line_i]] = 1'b1;
        next_state.ack_regs[flat_pos(int'(line_winner[ack_line_i]))] = 1'b1;
      end
    end
    still_pending = pending & ~clear;
    // Core-side masking of these lines is left to the core mask register
    for (int l = 0; l < NUM_LINES; l++) begin
      next_state.lines[l] = |(still_pending & line_mask(line_t'(l)));
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign core_line_one_o = state.lines[LINE_ONE];
  assign core_line_two_o = state.lines[LINE_TWO];
  assign core_line_three_o = state.lines[LINE_THREE];
  assign peripheral_vector_code_o = state.vector;
  assign core_vector_address_o = state.core_address;
  assign peripheral_acknowledge_regs_o = state.ack_regs;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_ack_on(line_t ln, src_idx_t src);
    ack_i && ack_line_i == ln && line_hit[ln] && line_winner[ln] == src;
  endsequence

  // A fresh event in the acknowledge cycle keeps its bit, so that case is left out here
  property p_maps(line_t ln, src_idx_t src, vector_t vec, int pos);
    s_ack_on(ln, src) ##0 !source_request_i[src] |=> peripheral_vector_code_o == vec
      && peripheral_acknowledge_regs_o[pos] && !pending[src];
  endproperty

  a_serial_tx_map: assert property (p_maps(2'h0, 5'h00, 16'h0007, 6))
    else $error("serial transmit mapping wrong");
  a_can_mbox_map: assert property (p_maps(2'h0, 5'h01, 16'h0040, 7))
    else $error("CAN mailbox mapping wrong");
  a_can_err_map: assert property (p_maps(2'h0, 5'h02, 16'h0041, 8))
    else $error("CAN error mapping wrong");
  a_t1_period_map: assert property (p_maps(2'h1, 5'h03, 16'h0027, 12))
    else $error("timer one period mapping wrong");
  a_t1_compare_map: assert property (p_maps(2'h1, 5'h04, 16'h0028, 13))
    else $error("timer one compare mapping wrong");
  a_t1_under_map: assert property (p_maps(2'h1, 5'h05, 16'h0029, 14))
    else $error("timer one underflow mapping wrong");
  a_t1_over_map: assert property (p_maps(2'h1, 5'h06, 16'h002A, 15))
    else $error("timer one overflow mapping wrong");
  a_t3_period_map: assert property (p_maps(2'h1, 5'h07, 16'h002F, 36))
    else $error("timer three period mapping wrong");
  a_t3_compare_map: assert property (p_maps(2'h1, 5'h08, 16'h0030, 37))
    else $error("timer three compare mapping wrong");
  a_t3_under_map: assert property (p_maps(2'h1, 5'h09, 16'h0031, 38))
    else $error("timer three underflow mapping wrong");
  a_t3_over_map: assert property (p_maps(2'h1, 5'h0A, 16'h0032, 39))
    else $error("timer three overflow mapping wrong");
  a_t2_period_map: assert property (p_maps(2'h2, 5'h0B, 16'h002B, 16))
    else $error("timer two period mapping wrong");
  a_t2_compare_map: assert property (p_maps(2'h2, 5'h0C, 16'h002C, 17))
    else $error("timer two compare mapping wrong");
  a_t2_under_map: assert property (p_maps(2'h2, 5'h0D, 16'h002D, 18))
    else $error("timer two underflow mapping wrong");
  a_t2_over_map: assert property (p_maps(2'h2, 5'h0E, 16'h002E, 19))
    else $error("timer two overflow mapping wrong");
  a_t4_period_map: assert property (p_maps(2'h2, 5'h0F, 16'h0039, 40))
    else $error("timer four period mapping wrong");
  a_t4_compare_map: assert property (p_maps(2'h2, 5'h10, 16'h003A, 41))
    else $error("timer four compare mapping wrong");
  a_t4_under_map: assert property (p_maps(2'h2, 5'h11, 16'h003B, 42))
    else $error("timer four underflow mapping wrong");
  a_t4_over_map: assert property (p_maps(2'h2, 5'h12, 16'h003C, 43))
    else $error("timer four overflow mapping wrong");

  a_line_two_addr: assert property (ack_i && ack_line_i == 2'h1
    |=> core_vector_address_o == 16'h0004)
    else $error("line two address wrong");
  a_line_three_addr: assert property (ack_i && ack_line_i == 2'h2
    |=> core_vector_address_o == 16'h0006)
    else $error("line three address wrong");
  a_lowest_first: assert property (ack_i && ack_line_i == 2'h1
    && pending[SRC_TIMER_ONE_PERIOD] |=> peripheral_vector_code_o == 16'h0027)
    else $error("line two did not present lowest priority number");
  a_tx_before_can: assert property (ack_i && ack_line_i == 2'h0
    && pending[SRC_SERIAL_TRANSMIT] |=> peripheral_vector_code_o == 16'h0007
    && (!$past(pending[SRC_CAN_MAILBOX]) || pending[SRC_CAN_MAILBOX]))
    else $error("line one arbitration wrong");
  a_phantom_empty: assert property (ack_i && ack_line_i != 2'h3
    && !line_hit[ack_line_i]
    |=> peripheral_vector_code_o == 16'h0000 && peripheral_acknowledge_regs_o == '0)
    else $error("empty acknowledge not phantom");
  a_line_follows: assert property (pending[SRC_TIMER_TWO_PERIOD] && !ack_i
    |=> core_line_three_o)
    else $error("line three not raised");
  a_ack_pulse: assert property (peripheral_acknowledge_regs_o != '0
    |=> peripheral_acknowledge_regs_o == '0 || $past(ack_i))
    else $error("acknowledge bits not a pulse");

  // ********************************************************************
  // Raise path, variants and acknowledge side
  // ********************************************************************
  logic [NUM_LINES-1:0] line_out;

  assign line_out = {core_line_three_o, core_line_two_o, core_line_one_o};

  // Step one: a present source with its enable up is taken at this edge
  sequence s_taken(src_idx_t src, bit present);
    present && source_request_i[src] && source_enable_i[src];
  endsequence

  // Step two: the core leaves the lines alone for one cycle
  sequence s_core_idle;
    !ack_i;
  endsequence

  property p_bit_up(src_idx_t src, bit present, int pos);
    s_taken(src, present) |=> peripheral_request_regs_o[pos];
  endproperty

  // The line lags the bit by one edge, so an acknowledge in between could drop it
  property p_line_up(src_idx_t src, bit present, line_t ln);
    s_taken(src, present) ##1 s_core_idle |=> line_out[ln];
  endproperty

  a_serial_bit_up: assert property (p_bit_up(5'h00, HAS_SERIAL, 6))
    else $error("serial transmit bit not set");
  a_serial_line_up: assert property (p_line_up(5'h00, HAS_SERIAL, 2'h0))
    else $error("line one not raised by serial transmit");
  a_can_bit_up: assert property (p_bit_up(5'h02, HAS_CAN, 8))
    else $error("CAN error bit not set");
  a_t1_line_up: assert property (p_line_up(5'h03, HAS_FIRST_EM, 2'h1))
    else $error("line two not raised by timer one period");
  a_t3_bit_up: assert property (p_bit_up(5'h0A, HAS_SECOND_EM, 39))
    else $error("timer three overflow bit not set");
  a_t3_line_up: assert property (p_line_up(5'h0A, HAS_SECOND_EM, 2'h1))
    else $error("line two not raised by timer three overflow");
  a_t2_bit_up: assert property (p_bit_up(5'h0B, HAS_FIRST_EM, 16))
    else $error("timer two period bit not set");
  a_t4_line_up: assert property (p_line_up(5'h12, HAS_SECOND_EM, 2'h2))
    else $error("line three not raised by timer four overflow");

  a_serial_absent: assert property (!HAS_SERIAL |-> !pending[SRC_SERIAL_TRANSMIT])
    else $error("absent serial source pending");
  a_can_absent: assert property (!HAS_CAN
    |-> !pending[SRC_CAN_MAILBOX] && !pending[SRC_CAN_ERROR])
    else $error("absent CAN source pending");
  a_first_em_absent: assert property (!HAS_FIRST_EM
    |-> !pending[SRC_TIMER_ONE_PERIOD] && !pending[SRC_TIMER_TWO_PERIOD])
    else $error("absent first event manager source pending");
  a_second_em_absent: assert property (!HAS_SECOND_EM
    |-> !pending[SRC_TIMER_THREE_OVERFLOW])
    else $error("absent second event manager source pending");

  a_set_wins_ack: assert property (s_ack_on(2'h2, SRC_TIMER_TWO_PERIOD)
    ##0 s_taken(SRC_TIMER_TWO_PERIOD, HAS_FIRST_EM) |=> pending[SRC_TIMER_TWO_PERIOD])
    else $error("event lost to a same-cycle acknowledge");
  a_line_one_addr: assert property (ack_i && ack_line_i == 2'h0
    |=> core_vector_address_o == 16'h0002)
    else $error("line one address wrong");
  a_invalid_no_clear: assert property (ack_i && ack_line_i == 2'h3
    |=> peripheral_acknowledge_regs_o == '0)
    else $error("ignored acknowledge cleared a source");
  a_vector_holds: assert property (!ack_i || ack_line_i == 2'h3
    |=> $stable(peripheral_vector_code_o) && $stable(core_vector_address_o))
    else $error("vector changed without acknowledge");
  a_ack_one_hot: assert property ($onehot0(peripheral_acknowledge_regs_o))
    else $error("more than one acknowledge bit");
  a_ack_was_pending: assert property (peripheral_acknowledge_regs_o != '0
    |-> ($past(peripheral_request_regs_o) & peripheral_acknowledge_regs_o) != '0)
    else $error("acknowledge bit for a source that was not pending");
  a_line_one_cause: assert property (core_line_one_o
    |-> $past(|peripheral_request_regs_o[8:6]))
    else $error("line one raised with nothing pending");
  a_line_two_cause: assert property (core_line_two_o
    |-> $past(|peripheral_request_regs_o[15:12] || |peripheral_request_regs_o[39:36]))
    else $error("line two raised with nothing pending");
  a_line_three_cause: assert property (core_line_three_o
    |-> $past(|peripheral_request_regs_o[19:16] || |peripheral_request_regs_o[43:40]))
    else $error("line three raised with nothing pending");

endmodule : peripheral_interrupt_expansion_map

`default_nettype wire

// ==== tb/cpu_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ********************************************************************
// Core side: takes one masked line at a time and acknowledges it
// ********************************************************************
module cpu_core_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [2:0] line_i,
  input wire logic [2:0] mask_i,
  input wire logic [3:0] delay_i,
  output logic ack_o,
  output logic [1:0] ack_line_o
);
  logic [3:0] wait_cnt;
  logic [1:0] pick;
  logic [2:0] open;

  assign open = line_i & mask_i;

  // Lower core line number wins, as the core itself would
  always_comb begin
    if (open[0]) begin
      pick = 2'h0;
    end else if (open[1]) begin
      pick = 2'h1;
    end else begin
      pick = 2'h2;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_o <= 1'b0;
      ack_line_o <= 2'h0;
      wait_cnt <= 4'h0;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      // Line select is meaningless outside a pulse, so scramble it
      ack_line_o <= ~ack_line_o;
      wait_cnt <= 4'h0;
    end else if (open == 3'h0) begin
      wait_cnt <= 4'h0;
    end else if (wait_cnt < delay_i) begin
      wait_cnt <= wait_cnt + 4'h1;
    end else begin
      ack_o <= 1'b1;
      ack_line_o <= pick;
    end
  end
endmodule : cpu_core_model

`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) check_val(48'(got), 48'(exp));

module tb import pie_map_pkg::*;;
  typedef struct packed {
    logic [15:0] vec;
    logic [5:0] pos;
    logic [1:0] ln;
  } exp_row_s;

  // ********************************************************************
  // Expected map: vector, word*16+bit, core line
  // ********************************************************************
  localparam exp_row_s EXP [NUM_SOURCES] = '{
    '{16'h0007, 6'h06, 2'h0},
    '{16'h0040, 6'h07, 2'h0},
    '{16'h0041, 6'h08, 2'h0},
    '{16'h0027, 6'h0C, 2'h1},
    '{16'h0028, 6'h0D, 2'h1},
    '{16'h0029, 6'h0E, 2'h1},
    '{16'h002A, 6'h0F, 2'h1},
    '{16'h002F, 6'h24, 2'h1},
    '{16'h0030, 6'h25, 2'h1},
    '{16'h0031, 6'h26, 2'h1},
    '{16'h0032, 6'h27, 2'h1},
    '{16'h002B, 6'h10, 2'h2},
    '{16'h002C, 6'h11, 2'h2},
    '{16'h002D, 6'h12, 2'h2},
    '{16'h002E, 6'h13, 2'h2},
    '{16'h0039, 6'h28, 2'h2},
    '{16'h003A, 6'h29, 2'h2},
    '{16'h003B, 6'h2A, 2'h2},
    '{16'h003C, 6'h2B, 2'h2}
  };
  localparam logic [15:0] EXP_ADDR [3] = '{16'h0002, 16'h0004, 16'h0006};

  logic clk_i;
  logic reset_i;
  logic [NUM_SOURCES-1:0] req;
  logic [NUM_SOURCES-1:0] ena;
  logic ack;
  logic [1:0] ack_line;
  logic [REQ_BITS-1:0] req_regs;
  logic [REQ_BITS-1:0] ack_regs;
  logic [REQ_BITS-1:0] req_regs_nocan;
  logic [15:0] vector_nocan;
  logic line_one;
  logic line_two;
  logic line_three;
  logic [2:0] lines;
  logic [15:0] vector;
  logic [15:0] address;
  logic [2:0] mask;
  logic [3:0] delay;
  int miscompares;
  int n_tests;
  int cycles;
  int n_ack;
  int k;

  assign lines = {line_three, line_two, line_one};

  peripheral_interrupt_expansion_map u_peripheral_interrupt_expansion_map (
    .clk_i(clk_i), .reset_i(reset_i), .source_request_i(req), .source_enable_i(ena),
    .ack_i(ack), .ack_line_i(ack_line), .peripheral_request_regs_o(req_regs),
    .peripheral_acknowledge_regs_o(ack_regs), .core_line_one_o(line_one),
    .core_line_two_o(line_two), .core_line_three_o(line_three),
    .peripheral_vector_code_o(vector), .core_vector_address_o(address)
  );

  // A variant without the CAN peripheral, fed the same traffic
  peripheral_interrupt_expansion_map #(.HAS_CAN(1'b0)) u_peripheral_interrupt_expansion_map_nocan (
    .clk_i(clk_i), .reset_i(reset_i), .source_request_i(req), .source_enable_i(ena),
    .ack_i(ack), .ack_line_i(ack_line), .peripheral_request_regs_o(req_regs_nocan),
    .peripheral_acknowledge_regs_o(), .core_line_one_o(), .core_line_two_o(),
    .core_line_three_o(), .peripheral_vector_code_o(vector_nocan), .core_vector_address_o()
  );

  cpu_core_model u_cpu_core_model (
    .clk_i(clk_i), .reset_i(reset_i), .line_i(lines), .mask_i(mask),
    .delay_i(delay), .ack_o(ack), .ack_line_o(ack_line)
  );

  // ********************************************************************
  // Access tasks
  // ********************************************************************
  task automatic check_val(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic conclude;
    $display("comparisons=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  // One-cycle event on the chosen sources with the given enables
  task automatic fire(input logic [NUM_SOURCES-1:0] m, input logic [NUM_SOURCES-1:0] en);
    @(posedge clk_i);
    req <= m;
    ena <= en;
    @(posedge clk_i);
    req <= '0;
    ena <= '1;
  endtask : fire

  // Open one core line, let the core acknowledge it, check the answer
  task automatic serve(input int ln, input logic [15:0] vec, input int pos, input logic [3:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    mask <= 3'h1 << ln;
    delay <= d;
    do begin
      @(negedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    @(posedge clk_i);
    mask <= 3'h0;
    @(negedge clk_i);
    `CHK(vector, vec)
    `CHK(address, EXP_ADDR[ln])
    `CHK(ack_regs, 48'h1 << pos)
    `CHK(req_regs[pos], 1'b0)
    @(negedge clk_i);
    `CHK(ack_regs, 48'h0)
  endtask : serve

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (ack === 1'b1) n_ack++;
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      conclude();
    end
  end

  // ********************************************************************
  // Tests
  // ********************************************************************
  initial begin
    reset_i = 1'b1;
    req = '0;
    ena = '1;
    mask = 3'h0;
    delay = 4'h0;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    `CHK(req_regs, 48'h0)
    `CHK({lines, vector, address}, 35'h0)
    $display("test reset done");

    for (int s = 0; s < NUM_SOURCES; s++) begin
      fire(19'h1 << s, '1);
      @(negedge clk_i);
      `CHK(req_regs, 48'h1 << EXP[s].pos)
      `CHK(req_regs_nocan & 48'h180, 48'h0)
      @(negedge clk_i);
      `CHK(lines, 3'h1 << EXP[s].ln)
      serve(EXP[s].ln, EXP[s].vec, EXP[s].pos, 4'h0);
      `CHK(vector_nocan, (s == 1 || s == 2) ? 16'h0000 : EXP[s].vec)
    end
    $display("test map done");

    fire(19'h2, ~19'h2);
    @(negedge clk_i);
    `CHK(req_regs, 48'h0)
    $display("test disabled done");

    k = n_ack;
    fire(19'h8, '1);
    repeat (10) @(negedge clk_i);
    `CHK(req_regs, 48'h1000)
    `CHK(n_ack, k)
    serve(1, 16'h0027, 12, 4'h3);
    $display("test hold done");

    fire(19'hC8, '1);
    serve(1, 16'h0027, 12, 4'h5);
    serve(1, 16'h002A, 15, 4'h0);
    serve(1, 16'h002F, 36, 4'h0);
    fire(19'h3, '1);
    serve(0, 16'h0007, 6, 4'h2);
    serve(0, 16'h0040, 7, 4'h0);
    `CHK(req_regs, 48'h0)
    $display("test priority done");
    conclude();
  end
endmodule : tb

`default_nettype wire
